/* File: shared/pll_ctrl_pkg.sv */
// Purpose: Shared constants for the synthesizer serial control block.
// Assumes: 50 MHz system clock, APB register access with 32-bit data.
// Notes:   Offsets are byte addresses of aligned 32-bit registers.
package pll_ctrl_pkg;

   // ----------------------------------------------------------------
   // Bus and register map
   // ----------------------------------------------------------------
   localparam int          ADDR_W      = 12;
   localparam int          DATA_W      = 32;
   localparam logic [11:0] CTRL_OFS    = 12'h000;
   localparam logic [11:0] STATUS_OFS  = 12'h004;
   localparam logic [11:0] DIVIDE_OFS  = 12'h008;
   localparam logic [2:0]  CTRL_RST    = 3'h0;

   // ----------------------------------------------------------------
   // Serial word layout
   // ----------------------------------------------------------------
   localparam logic [4:0]  BAND_BITS   = 5'h04;
   localparam logic [4:0]  WORD_SHORT  = 5'h12;
   localparam logic [4:0]  WORD_LONG   = 5'h13;
   localparam int          MAIN_W      = 10;
   localparam int          SWAL_W      = 5;

   // ----------------------------------------------------------------
   // Reference divider ratios
   // ----------------------------------------------------------------
   localparam logic [10:0] RATIO_512   = 11'h200;
   localparam logic [10:0] RATIO_640   = 11'h280;
   localparam logic [10:0] RATIO_1024  = 11'h400;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int          CLK_PERIOD_NS = 20;
   localparam int          LOCK_WIN_NS   = 200;
   localparam int          LOCK_WIN_CYC  =
      (LOCK_WIN_NS / CLK_PERIOD_NS < 1) ? 1 : LOCK_WIN_NS / CLK_PERIOD_NS;

   // ----------------------------------------------------------------
   // Test mode selections
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {PUMP_NORMAL, PUMP_HIZ, PUMP_SINK,
                             PUMP_SOURCE} pump_mode_t;

endpackage

/* File: src/pll_synth_serial_control.sv */
// Purpose: Serial control, dividers, phase comparator and lock detect.
// Assumes: Host keeps enable low when idle and holds it steady around
//          serial clock edges; crystal and prescaler arrive as pins.
// Notes:   Link logic runs on the falling serial clock edge.
// Functional notes
// - Serial data is shifted in on the first 19 falling serial clock edges of a frame.
// - Data and clock edges count only while enable is high.
// - An 18-bit word is latched when enable falls after 18 edges.
// - A 19-bit word is latched at the 19th falling edge by itself.
// - Ratio is 1/512 for 18 bits, 1/1024 or 1/640 (pin open) for 19.
// - The tuning step follows the received word length.
// - Each band output is on when its latched band bit is one.
// - Pump sources when divided VCO leads, sinks when it lags.
// - Lock detect is high while locked and low while unlocked.
// - Test mode puts divided VCO or reference on the lock pin.
// - Reference is the crystal divided by the selected ratio.
// - After reset bands are off, pump floats, 1/1024, lock high.
// - Total division is eight times 32M plus S.
// - Band bits apply after 4 edges; short words update bands only.
//
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module pll_synth_serial_control #(
   parameter int LOCK_WIN = pll_ctrl_pkg::LOCK_WIN_CYC
) (
   input  wire logic                           i_clk,      // System clock
   input  wire logic                           i_rst_n,    // Reset, low
   input  wire logic                           i_sclk,     // Serial clock
   input  wire logic                           i_sdata,    // Serial data
   input  wire logic                           i_enable,   // Serial enable
   input  wire logic                           i_ref_ratio_select_pin, // 1=open
   input  wire logic                           i_xtal,     // Crystal clock
   input  wire logic                           i_vco_div,  // Prescaler out
   input  wire logic                           psel,       // APB select
   input  wire logic                           penable,    // APB enable
   input  wire logic                           pwrite,     // APB write
   input  wire logic [pll_ctrl_pkg::ADDR_W-1:0] paddr,     // APB address
   input  wire logic [pll_ctrl_pkg::DATA_W-1:0] pwdata,    // APB wdata
   output logic      [pll_ctrl_pkg::DATA_W-1:0] prdata,    // APB rdata
   output logic                                pready,     // APB ready
   output logic                                pslverr,    // APB error
   output logic                                o_band_out_one,   // Band 1
   output logic                                o_band_out_two,   // Band 2
   output logic                                o_band_out_three, // Band 3
   output logic                                o_band_out_four,  // Band 4
   output logic                                o_pump_drive, // 1 src 0 snk
   output logic                                o_pump_oe,    // Pump drives
   output logic                                o_lock_or_test_out // Lock
);
   import pll_ctrl_pkg::*;

   initial begin
      if (LOCK_WIN < 1 || LOCK_WIN > 255) begin
         $error("LOCK_WIN must be 1 to 255");
      end
   end

   // ----------------------------------------------------------------
   // Link domain, falling serial clock
   // ----------------------------------------------------------------
   logic [4:0]  cnt_r, cnt_nxt;
   logic        band_done_r, band_done_nxt;
   logic        long_done_r, long_done_nxt;
   logic [18:0] shift_r, shift_nxt;
   logic [3:0]  band_hold_r, band_hold_nxt;
   logic [4:0]  snap_r, snap_nxt;

   always_comb begin
      cnt_nxt       = (cnt_r == WORD_LONG) ? cnt_r : cnt_r + 5'h01;
      band_done_nxt = (cnt_nxt >= BAND_BITS);
      long_done_nxt = (cnt_nxt == WORD_LONG);
      shift_nxt     = shift_r;
      band_hold_nxt = band_hold_r;
      snap_nxt      = snap_r;
      if (i_enable && cnt_r != WORD_LONG) begin
         shift_nxt = {shift_r[17:0], i_sdata};
         snap_nxt  = cnt_nxt;
         if (cnt_r == BAND_BITS - 5'h01) begin
            band_hold_nxt = {shift_r[2:0], i_sdata};
         end
      end
   end

   // Enable low holds the counter clear, so idle edges do nothing.
   always_ff @(negedge i_sclk or negedge i_enable) begin
      if (!i_enable) begin
         cnt_r       <= 5'h00;
         band_done_r <= 1'b0;
         long_done_r <= 1'b0;
      end else begin
         cnt_r       <= cnt_nxt;
         band_done_r <= band_done_nxt;
         long_done_r <= long_done_nxt;
      end
   end

   // The link clock may be stopped during reset, hence the async clear.
   always_ff @(negedge i_sclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         shift_r     <= 19'h0_0000;
         band_hold_r <= 4'h0;
         snap_r      <= 5'h00;
      end else begin
         shift_r     <= shift_nxt;
         band_hold_r <= band_hold_nxt;
         snap_r      <= snap_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Synchronisers into the system domain
   // ----------------------------------------------------------------
   logic [5:0] meta_r, sync_r, prev_r;
   logic [5:0] raw;
   logic       en_fall, band_rise, long_rise, xtal_rise, vco_rise;
   logic       pin_open;

   assign raw = {i_vco_div, i_xtal, i_ref_ratio_select_pin,
                 long_done_r, band_done_r, i_enable};

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         meta_r <= 6'h00;
         sync_r <= 6'h00;
         prev_r <= 6'h00;
      end else begin
         meta_r <= raw;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   assign en_fall   = prev_r[0] & ~sync_r[0];
   assign band_rise = sync_r[1] & ~prev_r[1];
   assign long_rise = sync_r[2] & ~prev_r[2];
   assign pin_open  = sync_r[3];
   assign xtal_rise = sync_r[4] & ~prev_r[4];
   assign vco_rise  = sync_r[5] & ~prev_r[5];

   // ----------------------------------------------------------------
   // Holding latches
   // ----------------------------------------------------------------
   logic [3:0]        band_r, band_nxt;
   logic [MAIN_W-1:0] main_r, main_nxt;
   logic [SWAL_W-1:0] swal_r, swal_nxt;
   logic              long_r, long_nxt;
   logic              por_r, por_nxt;

   always_comb begin
      band_nxt = band_r;
      main_nxt = main_r;
      swal_nxt = swal_r;
      long_nxt = long_r;
      por_nxt  = por_r;
      if (long_rise) begin
         band_nxt = shift_r[18:15];
         main_nxt = shift_r[14:5];
         swal_nxt = shift_r[4:0];
         long_nxt = 1'b1;
         por_nxt  = 1'b0;
      end else if (en_fall && snap_r == WORD_SHORT) begin
         band_nxt = shift_r[17:14];
         main_nxt = {1'b0, shift_r[13:5]};
         swal_nxt = shift_r[4:0];
         long_nxt = 1'b0;
         por_nxt  = 1'b0;
      end else if (band_rise || (en_fall && snap_r >= BAND_BITS &&
                                 snap_r < WORD_SHORT)) begin
         band_nxt = band_hold_r;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         band_r <= 4'h0;
         main_r <= '0;
         swal_r <= '0;
         long_r <= 1'b1;
         por_r  <= 1'b1;
      end else begin
         band_r <= band_nxt;
         main_r <= main_nxt;
         swal_r <= swal_nxt;
         long_r <= long_nxt;
         por_r  <= por_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Reference and main dividers
   // ----------------------------------------------------------------
   logic [10:0] ratio;
   logic [10:0] ref_cnt_r, ref_cnt_nxt;
   logic [14:0] vco_cnt_r, vco_cnt_nxt;
   logic [14:0] total;
   logic        ref_pulse, div_pulse;

   always_comb begin
      if (por_r) begin
         ratio = RATIO_1024;
      end else if (long_r) begin
         ratio = pin_open ? RATIO_640 : RATIO_1024;
      end else begin
         ratio = RATIO_512;
      end
   end

   // Prescaler output counts 32M+S, the prescaler supplies the eight.
   assign total     = {main_r, 5'h00} + {10'h000, swal_r};
   // Compare with >= so a smaller new ratio never waits for a wrap.
   assign ref_pulse = xtal_rise && (ref_cnt_r >= ratio - 11'h001);
   assign div_pulse = vco_rise && (vco_cnt_r >= total - 15'h0001);

   always_comb begin
      ref_cnt_nxt = ref_cnt_r;
      vco_cnt_nxt = vco_cnt_r;
      if (xtal_rise) begin
         ref_cnt_nxt = ref_pulse ? 11'h000 : ref_cnt_r + 11'h001;
      end
      if (vco_rise) begin
         vco_cnt_nxt = div_pulse ? 15'h0000 : vco_cnt_r + 15'h0001;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         ref_cnt_r <= 11'h000;
         vco_cnt_r <= 15'h0000;
      end else begin
         ref_cnt_r <= ref_cnt_nxt;
         vco_cnt_r <= vco_cnt_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Phase comparator, lock detect and test port
   // ----------------------------------------------------------------
   logic       src_r, src_nxt, snk_r, snk_nxt;
   logic [7:0] err_r, err_nxt;
   logic       lock_r, lock_nxt;
   logic       ref_tgl_r, ref_tgl_nxt, div_tgl_r, div_tgl_nxt;
   logic [2:0] ctrl_r, ctrl_nxt;
   pump_mode_t pmode;
   logic       drive_nxt, oe_nxt, lo_nxt;

   always_comb begin
      src_nxt = src_r | div_pulse;
      snk_nxt = snk_r | ref_pulse;
      err_nxt = err_r;
      lock_nxt = lock_r;
      if (src_nxt && snk_nxt) begin
         lock_nxt = (err_r <= 8'(LOCK_WIN));
         src_nxt  = 1'b0;
         snk_nxt  = 1'b0;
         err_nxt  = 8'h00;
      end else if ((src_r || snk_r) && err_r != 8'hFF) begin
         err_nxt = err_r + 8'h01;
      end
      ref_tgl_nxt = ref_tgl_r ^ ref_pulse;
      div_tgl_nxt = div_tgl_r ^ div_pulse;
   end

   always_comb begin
      case (ctrl_r[2:1])
         2'b00:   pmode = PUMP_NORMAL;
         2'b11:   pmode = ctrl_r[0] ? PUMP_SOURCE : PUMP_SINK;
         default: pmode = PUMP_HIZ;
      endcase
      case (pmode)
         PUMP_NORMAL: begin
            drive_nxt = src_nxt;
            oe_nxt    = src_nxt ^ snk_nxt;
         end
         PUMP_SOURCE: begin
            drive_nxt = 1'b1;
            oe_nxt    = 1'b1;
         end
         PUMP_SINK: begin
            drive_nxt = 1'b0;
            oe_nxt    = 1'b1;
         end
         default: begin
            drive_nxt = 1'b0;
            oe_nxt    = 1'b0;
         end
      endcase
      case (ctrl_r)
         3'b100:  lo_nxt = ref_tgl_nxt;
         3'b101:  lo_nxt = div_tgl_nxt;
         default: lo_nxt = lock_nxt;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         src_r              <= 1'b0;
         snk_r              <= 1'b0;
         err_r              <= 8'h00;
         lock_r             <= 1'b1;
         ref_tgl_r          <= 1'b0;
         div_tgl_r          <= 1'b0;
         o_pump_drive       <= 1'b0;
         o_pump_oe          <= 1'b0;
         o_lock_or_test_out <= 1'b1;
      end else begin
         src_r              <= src_nxt;
         snk_r              <= snk_nxt;
         err_r              <= err_nxt;
         lock_r             <= lock_nxt;
         ref_tgl_r          <= ref_tgl_nxt;
         div_tgl_r          <= div_tgl_nxt;
         o_pump_drive       <= drive_nxt;
         o_pump_oe          <= oe_nxt;
         o_lock_or_test_out <= lo_nxt;
      end
   end

   // Band pins follow the latched band bits one cycle later.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_band_out_one   <= 1'b0;
         o_band_out_two   <= 1'b0;
         o_band_out_three <= 1'b0;
         o_band_out_four  <= 1'b0;
      end else begin
         o_band_out_one   <= band_r[0];
         o_band_out_two   <= band_r[1];
         o_band_out_three <= band_r[2];
         o_band_out_four  <= band_r[3];
      end
   end

   // ----------------------------------------------------------------
   // APB slave, one wait-free access cycle after setup
   // ----------------------------------------------------------------
   logic [DATA_W-1:0] rdata_nxt;
   logic              ready_nxt, err_bus_nxt;
   logic              setup;

   assign setup = psel && !penable;

   always_comb begin
      ctrl_nxt    = ctrl_r;
      rdata_nxt   = '0;
      ready_nxt   = setup;
      err_bus_nxt = 1'b0;
      if (setup) begin
         case (paddr)
            CTRL_OFS: begin
               rdata_nxt = {29'h0000_0000, ctrl_r};
            end
            STATUS_OFS: begin
               rdata_nxt = {24'h00_0000, band_r, 1'b0, por_r, long_r,
                            lock_r};
            end
            DIVIDE_OFS: begin
               rdata_nxt = {5'h00, ratio, 1'b0, main_r, swal_r};
            end
            default: begin
               err_bus_nxt = 1'b1;
            end
         endcase
      end
      // A write lands only at the access edge that sees pready high.
      if (psel && penable && pready && pwrite && paddr == CTRL_OFS) begin
         ctrl_nxt = pwdata[2:0];
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         ctrl_r  <= CTRL_RST;
         prdata  <= '0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         ctrl_r  <= ctrl_nxt;
         prdata  <= rdata_nxt;
         pready  <= ready_nxt;
         pslverr <= err_bus_nxt;
      end
   end

endmodule
`default_nettype wire

/* File: tb/host_link_model.sv */
// Purpose: Host end of the three-wire serial link.
// Assumes: Link clock of 64 ns runs free inside the model only.
// Notes:   Serial clock stands low outside frames except for stray pulses; idle data toggles.
`timescale 1ns/1ps
`default_nettype none
module host_link_model (
   output logic o_sclk,  // Serial clock
   output logic o_sdata, // Serial data
   output logic o_enable // Frame enable
);
   logic lclk;
   initial begin
      lclk = 1'b0;
      o_sclk = 1'b0;
      o_sdata = 1'b0;
      o_enable = 1'b0;
      #7;
      forever #32 lclk = ~lclk;
   end
   // Opens a frame and sends n bits, first bit first; frame stays open.
   task automatic send(input logic [20:0] w, input int n);
      @(posedge lclk);
      o_enable = 1'b1;
      for (int k = n - 1; k >= 0; k--) begin
         @(posedge lclk);
         o_sdata = w[k];
         o_sclk = 1'b1;
         @(negedge lclk);
         o_sclk = 1'b0;
      end
      @(posedge lclk);
   endtask
   // Closes the frame, then keeps the gap before the next one.
   task automatic close_frame();
      repeat (4) @(posedge lclk);
      o_enable = 1'b0;
      o_sdata = ~o_sdata;
      repeat (80) @(posedge lclk);
   endtask
   // Clock pulses with enable low, which the device must ignore.
   task automatic stray(input int n);
      repeat (n) begin
         @(posedge lclk);
         o_sdata = ~o_sdata;
         o_sclk = 1'b1;
         @(negedge lclk);
         o_sclk = 1'b0;
      end
   endtask
endmodule
`default_nettype wire

/* File: tb/pll_ctrl_checker.sv */
// Purpose: Port-level checks of the synthesizer control block.
// Assumes: Sees only the top module ports.
// Notes:   Tracks the test mode from completed APB writes.
`timescale 1ns/1ps
`default_nettype none
module pll_ctrl_checker (
   input wire logic                              i_clk,   // Clock
   input wire logic                              i_rst_n, // Reset
   input wire logic                              i_enable,// Enable
   input wire logic                              psel,    // Select
   input wire logic                              penable, // Access
   input wire logic                              pwrite,  // Write
   input wire logic [pll_ctrl_pkg::ADDR_W-1:0]   paddr,   // Address
   input wire logic [pll_ctrl_pkg::DATA_W-1:0]   pwdata,  // Wdata
   input wire logic [pll_ctrl_pkg::DATA_W-1:0]   prdata,  // Rdata
   input wire logic                              pready,  // Ready
   input wire logic                              pslverr, // Error
   input wire logic                              o_band_out_one,
   input wire logic                              o_band_out_two,
   input wire logic                              o_band_out_three,
   input wire logic                              o_band_out_four,
   input wire logic                              o_pump_drive,
   input wire logic                              o_pump_oe,
   input wire logic                              o_lock_or_test_out
);
   import pll_ctrl_pkg::*;
   logic [2:0] mode_r;
   logic [2:0] mode_nxt;
   logic [3:0] band;
   assign band = {o_band_out_four, o_band_out_three, o_band_out_two,
                  o_band_out_one};
   always_comb begin
      mode_nxt = mode_r;
      if (psel && penable && pready && pwrite && paddr == CTRL_OFS)
         mode_nxt = pwdata[2:0];
   end
   always_ff @(posedge i_clk) begin
      if (!i_rst_n)
         mode_r <= CTRL_RST;
      else
         mode_r <= mode_nxt;
   end
   a_ready_after_setup: assert property (@(posedge i_clk)
      disable iff (!i_rst_n) psel && !penable |=> pready)
      else $error("no ready after setup");
   a_ready_in_access: assert property (@(posedge i_clk)
      disable iff (!i_rst_n) pready |-> psel && penable)
      else $error("ready outside access");
   a_ready_one_cycle: assert property (@(posedge i_clk)
      disable iff (!i_rst_n) pready |=> !pready)
      else $error("ready held too long");
   a_error_clean_data: assert property (@(posedge i_clk)
      disable iff (!i_rst_n) pslverr |-> pready && prdata == '0)
      else $error("bad error response");
   a_reset_outputs: assert property (@(posedge i_clk) !i_rst_n |=>
      band == 4'h0 && !o_pump_oe && o_lock_or_test_out && !pready)
      else $error("wrong state after reset");
   a_bands_quiet: assert property (@(posedge i_clk)
      disable iff (!i_rst_n) !i_enable [*8] |=> $stable(band))
      else $error("bands moved while idle");
   a_pump_sink: assert property (@(posedge i_clk)
      disable iff (!i_rst_n) mode_r == 3'h6 [*3] |-> o_pump_oe && !o_pump_drive)
      else $error("pump not sinking");
   a_pump_source: assert property (@(posedge i_clk)
      disable iff (!i_rst_n) mode_r == 3'h7 [*3] |-> o_pump_oe && o_pump_drive)
      else $error("pump not sourcing");
   a_pump_float: assert property (@(posedge i_clk)
      disable iff (!i_rst_n) (mode_r[2] != mode_r[1]) [*3] |-> !o_pump_oe)
      else $error("pump not floating");
endmodule
bind pll_synth_serial_control pll_ctrl_checker chk (.i_clk, .i_rst_n,
   .i_enable, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
   .pslverr, .o_band_out_one, .o_band_out_two, .o_band_out_three,
   .o_band_out_four, .o_pump_drive, .o_pump_oe, .o_lock_or_test_out);
`default_nettype wire

/* File: tb/tb_top.sv */
// Purpose: Self-checking bench of the synthesizer control block.
// Assumes: Crystal and prescaler inputs toggle every 6 clocks.
// Notes:   Words come from an LFSR with a fixed start value.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import pll_ctrl_pkg::*;
   logic              i_clk, i_rst_n, i_sclk, i_sdata, i_enable, i_pin;
   logic              i_xtal, i_vco_div, psel, penable, pwrite, pready;
   logic              pslverr, err, b1, b2, b3, b4, drv, oe, lk;
   logic [ADDR_W-1:0] paddr;
   logic [31:0]       pwdata, prdata, rd, lfsr_r, div_e, st_e;
   int                n_fail, comparisons, ph, h;
   host_link_model host (.o_sclk(i_sclk), .o_sdata(i_sdata),
      .o_enable(i_enable));
   pll_synth_serial_control dut (.i_clk, .i_rst_n, .i_sclk, .i_sdata,
      .i_enable, .i_ref_ratio_select_pin(i_pin), .i_xtal, .i_vco_div, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .o_band_out_one(b1), .o_band_out_two(b2), .o_band_out_three(b3),
      .o_band_out_four(b4), .o_pump_drive(drv), .o_pump_oe(oe),
      .o_lock_or_test_out(lk));
   always #10 i_clk = ~i_clk;
   always @(posedge i_clk) begin
      ph <= (ph == 5) ? 0 : ph + 1;
      if (ph == 5) begin
         i_xtal <= ~i_xtal;
         i_vco_div <= ~i_vco_div;
      end
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [31:0] exp_div(input logic [10:0] r,
      input logic [9:0] m, input logic [4:0] s);
      return {5'h00, r, 1'b0, m, s};
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      int t;
      @(posedge i_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge i_clk);
      penable <= 1'b1;
      t = 0;
      do begin
         @(posedge i_clk);
         t++;
      end while (pready !== 1'b1 && t < 50);
      if (t == 50)
         n_fail++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic frame(input int n, input logic [20:0] w);
      logic [18:0] v;
      host.send(w, n);
      if (n >= 19) begin
         v = 19'(w >> (n - 19));
         div_e = exp_div(i_pin ? RATIO_640 : RATIO_1024, v[14:5], v[4:0]);
         st_e = {24'h0000_00, v[18:15], 4'h2};
         repeat (10) @(posedge i_clk);
         apb(1'b0, DIVIDE_OFS, '0);
         check(rd, div_e);
      end
      host.close_frame();
      if (n == 18) begin
         div_e = exp_div(RATIO_512, {1'b0, w[13:5]}, w[4:0]);
         st_e = {24'h0000_00, w[17:14], 4'h0};
      end
      if (n >= 4 && n < 18)
         st_e[7:4] = w[n-1 -: 4];
      apb(1'b0, DIVIDE_OFS, '0);
      check(rd, div_e);
      apb(1'b0, STATUS_OFS, '0);
      check(rd & 32'h0000_00F6, st_e);
      check({28'h0000_000, b4, b3, b2, b1}, {28'h0000_000, st_e[7:4]});
   endtask
   // Cycles between two changes of the lock pin in a test mode.
   task automatic measure(input logic [2:0] md, input int half);
      int t;
      logic lv;
      apb(1'b1, CTRL_OFS, {29'h0000_0000, md});
      // Let the mode switch itself reach the pin before timing edges.
      repeat (4) @(posedge i_clk);
      for (int k = 0; k < 2; k++) begin
         t = 0;
         lv = lk;
         do begin
            @(posedge i_clk);
            t++;
         end while (lk === lv && t < 40000);
      end
      check(32'(t), 32'(half));
   endtask
   task automatic close_out();
      $display("checks=%0d mismatches=%0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // Longest expected run is about 42500 cycles.
   initial begin
      #1_900_000;
      n_fail++;
      close_out();
   end
   initial begin
      {i_clk, i_rst_n, i_pin, i_xtal, i_vco_div, psel, penable} = '0;
      {pwrite, paddr, pwdata, ph, n_fail, comparisons} = '0;
      lfsr_r = 32'h77da_bdce;
      st_e = 32'h0000_0006;
      div_e = exp_div(RATIO_1024, '0, '0);
      repeat (8) @(posedge i_clk);
      check({25'h0, b4, b3, b2, b1, oe, drv, lk}, 32'h0000_0001);
      i_rst_n <= 1'b1;
      apb(1'b0, CTRL_OFS, '0);
      check(rd, 32'h0000_0000);
      apb(1'b1, 12'h00C, 32'hFFFF_FFFF);
      check({31'h0, err}, 32'h0000_0001);
      apb(1'b1, STATUS_OFS, 32'hFFFF_FFFF);
      apb(1'b0, STATUS_OFS, '0);
      check(rd & 32'h0000_00F6, st_e);
      frame(3, 21'h00_0007);
      lfsr_r = lfsr(lfsr_r);
      frame(10, lfsr_r[20:0]);
      host.stray(3);
      lfsr_r = lfsr(lfsr_r);
      frame(18, lfsr_r[20:0]);
      lfsr_r = lfsr(lfsr_r);
      frame(21, lfsr_r[20:0]);
      i_pin <= 1'b1;
      lfsr_r = lfsr(lfsr_r);
      frame(19, {lfsr_r[20:17], 10'h020, lfsr_r[4:0]});
      h = (1024 + int'(lfsr_r[4:0])) * 12;
      for (int md = 0; md < 8; md++) begin
         apb(1'b1, CTRL_OFS, 32'(md));
         apb(1'b0, CTRL_OFS, '0);
         check(rd, 32'(md));
         repeat (4) @(posedge i_clk);
         if (md >= 2)
            check({30'h0, oe, oe & drv}, {30'h0, md >= 6, md == 7});
      end
      measure(3'h4, 640 * 12);
      measure(3'h5, h);
      close_out();
   end
endmodule
`default_nettype wire
